//--- rtsr_regs.vh
// register offsets, field positions and reset values of the test and status register group
`ifndef RTSR_REGS_VH
`define RTSR_REGS_VH

// register indices as printed; byte address is four times the index
`define RTSR_IDX_ADC_TEST     8'h25
`define RTSR_IDX_COUPLER      8'h26
`define RTSR_IDX_STAGE        8'h27
`define RTSR_IDX_STATUS       8'h40
`define RTSR_IDX_RST_FLAGS    8'h41
`define RTSR_IDX_COMPARE      8'h47
`define RTSR_IDX_IRQ_STATUS   8'h50
`define RTSR_IDX_IRQ_MASK     8'h51

// reset values
`define RTSR_RST_ADC_TEST     8'h40
`define RTSR_RST_COUPLER      8'h00
`define RTSR_RST_STAGE        8'h00
`define RTSR_RST_IRQ          8'h00

// adc_test_control fields
`define RTSR_B_FCOMP_EN       7
`define RTSR_B_DITHER         6
`define RTSR_B_ADC_OUT        5
`define RTSR_B_CHOP_OFF       4
`define RTSR_B_SHAPE_OFF      3
`define RTSR_B_VCM_OFF        2
`define RTSR_F_ROTATE         1:0

// gain_coupler_override fields
`define RTSR_B_GAIN_OVR       3
`define RTSR_B_AC1            2
`define RTSR_F_AC2            1:0
`define RTSR_M_COUPLER        8'h0F
`define RTSR_M_STAGE          8'h3F

// gain_stage_override fields
`define RTSR_F_STAGE1         5:4
`define RTSR_F_STAGE2         3:2
`define RTSR_F_STAGE3         1:0

// rotation modes
`define RTSR_ROT_SEQ_A        2'h0
`define RTSR_ROT_SEQ_B        2'h1
`define RTSR_ROT_HOLD         2'h2
`define RTSR_ROT_ALT          2'h3

// interrupt event bits
`define RTSR_EV_CAL_DONE      0
`define RTSR_EV_LOCK_FAIL     1
`define RTSR_EV_LOCK_LOST     2
`define RTSR_EV_CARRIER       3
`define RTSR_EV_WIDTH         4

`endif

//--- rtsr_regs.v
// test-override and status register group with apb slave and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "rtsr_regs.vh"

// What this block does
// (R01) comparator output enabled by freq_comparator_enable, resets 0
// (R02) dither_clock_enable enables dithering, resets 1
// (R03) adc test output drives samples onto pins
// (R04) three converter technique disable bits, reset 0
// (R05) rotation field selects converter input sequence
// (R06) gain override applies first coupler gain
// (R07) second coupler gain two-bit override
// (R08) stage gain register, reserved bits zero
// (R09) cal finished clears at start, sets done
// (R10) lock failure flagged during power-up sequencing
// (R11) report instantaneous and filtered lock
// (R12) carrier sense when strength exceeds threshold
// (R13) low status bits show pin levels
// (R14) reset-done flags per subsystem
// (R15) bit-sync done needs all three parts
// (R16) comparator output readable in status three
// (R17) reads never alter status bits
module rtsr_regs (
  input  wire        clk,               // 100 MHz system clock
  input  wire        rst_n,             // async active-low reset
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // hardware status inputs (asynchronous)
  input  wire        cal_start,         // pll calibration started
  input  wire        cal_end,           // pll calibration finished
  input  wire        seq_lock_fail,     // lock missed in power-up sequence
  input  wire        lock_now,          // instantaneous lock
  input  wire        lock_filtered,     // lock qualified by tolerance
  input  wire [6:0]  signal_strength_level,
  input  wire [6:0]  carrier_threshold,
  input  wire        freq_comp_raw,     // phase detector comparator
  input  wire [7:0]  subsys_done_raw,   // per subsystem done, bit 3 unused
  input  wire [2:0]  bitsync_parts_done, // modulator, bit sync, prbs
  // converter sample path
  input  wire        converter_sample_a,
  input  wire        converter_sample_b,
  input  wire        converter_sample_clock,
  // normal pin sources
  input  wire        lock_src,
  input  wire        data_src,
  input  wire        data_clock_src,
  // pin drives
  output reg         lock_pin,
  output reg         data_pin,
  output reg         data_clock_pin,
  // analog controls
  output reg         freq_comp_out,
  output wire        dither_clock_enable,
  output wire        integrator_chop_off,
  output wire        feedback_shaping_off,
  output wire        common_mode_rotation_off,
  output reg  [1:0]  adc_input_position,
  output reg         first_coupler_gain,
  output reg  [1:0]  second_coupler_gain,
  output wire        gain_override_enable,
  output wire [1:0]  stage1_gain_value,
  output wire [1:0]  stage2_gain_value,
  output wire [1:0]  stage3_gain_value,
  output wire        irq
);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  reg  [1:0]  rst_sync_r;              // reset release pair
  wire        rst_q_n = rst_sync_r[1]; // synchronised reset

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'h0;
    else        rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  localparam SW = 32;                  // synchronised bundle width
  wire [SW-1:0] async_in = {cal_start, cal_end, seq_lock_fail, lock_now,
                            lock_filtered, freq_comp_raw, subsys_done_raw,
                            bitsync_parts_done, lock_src, data_src,
                            data_clock_src, converter_sample_a,
                            converter_sample_b, converter_sample_clock,
                            7'h00, 2'h0};
  reg  [SW-1:0] s1_r;                  // first stage, read only by s2
  reg  [SW-1:0] s2_r;                  // second stage

  // two flip-flop synchroniser
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      s1_r <= 32'h0;
      s2_r <= 32'h0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
    end
  end

  wire       y_cal_start  = s2_r[31];
  wire       y_cal_end    = s2_r[30];
  wire       y_seq_fail   = s2_r[29];
  wire       y_lock_now   = s2_r[28];
  wire       y_lock_filt  = s2_r[27];
  wire       y_fcomp      = s2_r[26];
  wire [7:0] y_done       = s2_r[25:18];
  wire [2:0] y_bs_parts   = s2_r[17:15];
  wire       y_lock_src   = s2_r[14];
  wire       y_data_src   = s2_r[13];
  wire       y_clkp_src   = s2_r[12];
  wire       y_samp_a     = s2_r[11];
  wire       y_samp_b     = s2_r[10];
  wire       y_samp_clk   = s2_r[9];

  // strength and threshold pass two stages before the compare
  // both are slow levels: a word caught mid-change settles one cycle later
  reg  [6:0] strength_s1_r;            // strength, first stage
  reg  [6:0] strength_r;               // strength, second stage
  reg  [6:0] thr_s1_r;                 // threshold, first stage
  reg  [6:0] thr_r;                    // threshold, second stage
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      strength_s1_r <= 7'h00;
      strength_r    <= 7'h00;
      thr_s1_r      <= 7'h00;
      thr_r         <= 7'h00;
    end else begin
      strength_s1_r <= signal_strength_level;
      strength_r    <= strength_s1_r;
      thr_s1_r      <= carrier_threshold;
      thr_r         <= thr_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // writable test registers
  // ----------------------------------------------------------------
  reg [7:0] adc_test_r;                // adc_test_control
  reg [7:0] coupler_r;                 // gain_coupler_override
  reg [7:0] stage_r;                   // gain_stage_override
  reg [7:0] irq_mask_r;                // interrupt mask
  reg [7:0] irq_stat_r;                // sticky interrupt status
  reg [7:0] irq_stat_nxt;

  wire       acc   = psel & penable;   // access phase, zero wait
  wire       wr_en = acc & pwrite;
  wire [9:0] idx   = paddr[11:2];      // word index

  function hit;                        // index match on a word address
    input [9:0] i;
    input [7:0] want;
    begin
      hit = (i == {2'h0, want}) && (paddr[1:0] == 2'h0);
    end
  endfunction

  assign pready  = 1'b1;
  wire   mapped  = hit(idx, `RTSR_IDX_ADC_TEST) | hit(idx, `RTSR_IDX_COUPLER) |
                   hit(idx, `RTSR_IDX_STAGE) | hit(idx, `RTSR_IDX_STATUS) |
                   hit(idx, `RTSR_IDX_RST_FLAGS) | hit(idx, `RTSR_IDX_COMPARE) |
                   hit(idx, `RTSR_IDX_IRQ_STATUS) | hit(idx, `RTSR_IDX_IRQ_MASK);
  assign pslverr = acc & ~mapped;      // unmapped address errors

  // register writes
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      adc_test_r <= `RTSR_RST_ADC_TEST;  // [R01] [R02] [R04]
      coupler_r  <= `RTSR_RST_COUPLER;
      stage_r    <= `RTSR_RST_STAGE;     // [R08]
      irq_mask_r <= `RTSR_RST_IRQ;
    end else if (wr_en) begin
      if (hit(idx, `RTSR_IDX_ADC_TEST)) adc_test_r <= pwdata[7:0];
      // reserved bits held at zero
      if (hit(idx, `RTSR_IDX_COUPLER))  coupler_r  <= pwdata[7:0] & `RTSR_M_COUPLER;
      if (hit(idx, `RTSR_IDX_STAGE))    stage_r    <= pwdata[7:0] & `RTSR_M_STAGE; // [R08]
      if (hit(idx, `RTSR_IDX_IRQ_MASK)) irq_mask_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  assign dither_clock_enable      = adc_test_r[`RTSR_B_DITHER];    // [R02]
  assign integrator_chop_off      = adc_test_r[`RTSR_B_CHOP_OFF];  // [R04]
  assign feedback_shaping_off     = adc_test_r[`RTSR_B_SHAPE_OFF]; // [R04]
  assign common_mode_rotation_off = adc_test_r[`RTSR_B_VCM_OFF];   // [R04]
  assign gain_override_enable     = coupler_r[`RTSR_B_GAIN_OVR];
  assign stage1_gain_value        = stage_r[`RTSR_F_STAGE1];       // [R08]
  assign stage2_gain_value        = stage_r[`RTSR_F_STAGE2];
  assign stage3_gain_value        = stage_r[`RTSR_F_STAGE3];

  // coupler overrides only take effect while override is enabled
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      first_coupler_gain  <= 1'b0;
      second_coupler_gain <= 2'h0;
      freq_comp_out       <= 1'b0;
    end else begin
      first_coupler_gain  <= gain_override_enable & coupler_r[`RTSR_B_AC1]; // [R06]
      second_coupler_gain <= gain_override_enable ?
                             coupler_r[`RTSR_F_AC2] : 2'h0;                 // [R07]
      freq_comp_out       <= adc_test_r[`RTSR_B_FCOMP_EN] & y_fcomp;         // [R01]
    end
  end

  // rotation sequencer steps once per rising converter sample clock edge
  reg       samp_clk_d_r;              // previous sample clock
  reg [1:0] rot_step_r;                // sequence step
  wire      samp_rise = y_samp_clk & ~samp_clk_d_r;

  function [1:0] rot_pos;              // position for mode and step
    input [1:0] mode;
    input [1:0] step;
    begin
      case (mode)
        `RTSR_ROT_SEQ_A: rot_pos = step;
        `RTSR_ROT_SEQ_B: begin
          case (step)
            2'h0:    rot_pos = 2'h0;
            2'h1:    rot_pos = 2'h2;
            2'h2:    rot_pos = 2'h3;
            default: rot_pos = 2'h1;
          endcase
        end
        `RTSR_ROT_HOLD:  rot_pos = 2'h0;
        default:         rot_pos = {step[0], 1'b0};
      endcase
    end
  endfunction

  // step counter and position output
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      samp_clk_d_r       <= 1'b0;
      rot_step_r         <= 2'h0;
      adc_input_position <= 2'h0;
    end else begin
      samp_clk_d_r <= y_samp_clk;
      if (samp_rise) rot_step_r <= rot_step_r + 2'h1;
      adc_input_position <= rot_pos(adc_test_r[`RTSR_F_ROTATE], rot_step_r); // [R05]
    end
  end

  // pin mux: test mode routes converter samples to the pins
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      lock_pin       <= 1'b0;
      data_pin       <= 1'b0;
      data_clock_pin <= 1'b0;
    end else if (adc_test_r[`RTSR_B_ADC_OUT]) begin
      lock_pin       <= y_samp_a;    // [R03]
      data_pin       <= y_samp_b;    // [R03]
      data_clock_pin <= y_samp_clk;  // [R03]
    end else begin
      lock_pin       <= y_lock_src;
      data_pin       <= y_data_src;
      data_clock_pin <= y_clkp_src;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  reg cal_done_r;                      // calibration finished
  reg lock_fail_r;                     // power-up lock failure
  reg carrier_r;                       // carrier sense
  reg lock_filt_d_r;                   // for loss-of-lock event

  // flags follow hardware only, never the bus
  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      cal_done_r    <= 1'b0;
      lock_fail_r   <= 1'b0;
      carrier_r     <= 1'b0;
      lock_filt_d_r <= 1'b0;
    end else begin
      if (y_cal_start)    cal_done_r <= 1'b0;   // [R09]
      else if (y_cal_end) cal_done_r <= 1'b1;   // [R09]
      if (y_cal_start)    lock_fail_r <= 1'b0;
      else if (y_seq_fail) lock_fail_r <= 1'b1; // [R10]
      carrier_r     <= (strength_r > thr_r);    // [R12]
      lock_filt_d_r <= y_lock_filt;
    end
  end

  wire [7:0] status_v = {cal_done_r, lock_fail_r, y_lock_now, y_lock_filt, // [R11]
                         carrier_r, lock_pin, data_clock_pin, data_pin};   // [R13]
  // bit-sync done only when all three parts are done
  wire [7:0] flags_v  = {y_done[7:4], &y_bs_parts, y_done[2:0]};           // [R14] [R15]
  wire [7:0] comp_v   = {y_fcomp, 7'h00};                                  // [R16]

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  reg        cal_done_d_r;             // edge detect of calibration done
  reg        lock_fail_d_r;
  reg        carrier_d_r;
  wire [7:0] ev = {4'h0,
                   carrier_r & ~carrier_d_r,
                   lock_filt_d_r & ~y_lock_filt,
                   lock_fail_r & ~lock_fail_d_r,
                   cal_done_r & ~cal_done_d_r};
  wire [7:0] w1c = (wr_en & hit(idx, `RTSR_IDX_IRQ_STATUS)) ? pwdata[7:0] : 8'h00;

  always @* begin
    irq_stat_nxt = (irq_stat_r & ~w1c) | ev;
  end

  always @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      irq_stat_r    <= `RTSR_RST_IRQ;
      cal_done_d_r  <= 1'b0;
      lock_fail_d_r <= 1'b0;
      carrier_d_r   <= 1'b0;
    end else begin
      irq_stat_r    <= irq_stat_nxt;
      cal_done_d_r  <= cal_done_r;
      lock_fail_d_r <= lock_fail_r;
      carrier_d_r   <= carrier_r;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // read mux; reads have no side effects
  // ----------------------------------------------------------------
  always @* begin
    prdata = 32'h0;
    if (acc && !pwrite) begin
      if (hit(idx, `RTSR_IDX_ADC_TEST))   prdata[7:0] = adc_test_r;
      if (hit(idx, `RTSR_IDX_COUPLER))    prdata[7:0] = coupler_r;
      if (hit(idx, `RTSR_IDX_STAGE))      prdata[7:0] = stage_r;
      if (hit(idx, `RTSR_IDX_STATUS))     prdata[7:0] = status_v;   // [R17]
      if (hit(idx, `RTSR_IDX_RST_FLAGS))  prdata[7:0] = flags_v;    // [R17]
      if (hit(idx, `RTSR_IDX_COMPARE))    prdata[7:0] = comp_v;
      if (hit(idx, `RTSR_IDX_IRQ_STATUS)) prdata[7:0] = irq_stat_r;
      if (hit(idx, `RTSR_IDX_IRQ_MASK))   prdata[7:0] = irq_mask_r;
    end
  end

endmodule // rtsr_regs
`default_nettype wire

//--- rtsr_host.sv
// host model: apb master that reaches the test and status registers
`timescale 1ns/100ps
`default_nettype none
module rtsr_host (
  input  wire logic        clk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // bus idle from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // ------------------------------------------------------------
  // one transfer: setup, access held until pready, then release
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_d, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_d = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // rtsr_host
`default_nettype wire

//--- rtsr_regs_sva.sv
// checker: register write effects, refusals and interrupt masking
`timescale 1ns/100ps
`default_nettype none
module rtsr_regs_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        dither_clock_enable,
  input wire logic        integrator_chop_off,
  input wire logic        feedback_shaping_off,
  input wire logic        common_mode_rotation_off,
  input wire logic        first_coupler_gain,
  input wire logic [1:0]  second_coupler_gain,
  input wire logic        gain_override_enable,
  input wire logic [1:0]  stage1_gain_value,
  input wire logic [1:0]  stage2_gain_value,
  input wire logic [1:0]  stage3_gain_value,
  input wire logic        irq
);
  wire wr = psel & penable & pwrite;       // write taken this edge
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dither; wr && paddr == 12'h094 |=> dither_clock_enable == $past(pwdata[6]); endproperty
  a_dither: assert property (p_dither) else $error("dither bit mismatch");
  property p_keep; !(wr && paddr == 12'h094) |=> $stable(dither_clock_enable); endproperty
  a_keep: assert property (p_keep) else $error("dither changed unasked");
  property p_chop; wr && paddr == 12'h094 |=> integrator_chop_off == $past(pwdata[4]); endproperty
  a_chop: assert property (p_chop) else $error("chop bit mismatch");
  property p_shape; wr && paddr == 12'h094 |=> feedback_shaping_off == $past(pwdata[3]); endproperty
  a_shape: assert property (p_shape) else $error("shaping bit mismatch");
  property p_vcm; wr && paddr == 12'h094 |=> common_mode_rotation_off == $past(pwdata[2]); endproperty
  a_vcm: assert property (p_vcm) else $error("rotation off bit mismatch");
  property p_ovr; wr && paddr == 12'h098 |=> gain_override_enable == $past(pwdata[3]); endproperty
  a_ovr: assert property (p_ovr) else $error("override enable mismatch");
  property p_nogain;
    !gain_override_enable [*2] |-> !first_coupler_gain && second_coupler_gain == 2'h0;
  endproperty
  a_nogain: assert property (p_nogain) else $error("coupler gain without override");
  property p_stage;
    wr && paddr == 12'h09C |=>
      {stage1_gain_value, stage2_gain_value, stage3_gain_value} == $past(pwdata[5:0]);
  endproperty
  a_stage: assert property (p_stage) else $error("stage gain mismatch");
  property p_err; psel && penable && paddr[1:0] != 2'h0 |-> pslverr && pready; endproperty
  a_err: assert property (p_err) else $error("misaligned access not refused");
  property p_idle; !(psel && penable) |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_irq; wr && paddr == 12'h144 && pwdata[3:0] == 4'h0 |=> ##[0:1] !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq high with all masked");
endmodule // rtsr_regs_sva
bind rtsr_regs rtsr_regs_sva u_sva (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .dither_clock_enable, .integrator_chop_off, .feedback_shaping_off,
  .common_mode_rotation_off, .first_coupler_gain, .second_coupler_gain, .gain_override_enable,
  .stage1_gain_value, .stage2_gain_value, .stage3_gain_value, .irq);
`default_nettype wire

//--- rtsr_regs_tb_top.sv
// testbench: register model compared with the register group
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, x, g) begin num_checks++; if ((g) !== (x)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, x, g); end end
module rtsr_regs_tb_top;
  logic clk = 0, rst_n = 0, e;
  logic cal_start = 0, cal_end = 0, seq_lock_fail = 0, lock_now = 0, lock_filtered = 0;
  logic freq_comp_raw = 0, converter_sample_a = 0, converter_sample_b = 0;
  logic converter_sample_clock = 0, lock_src = 0, data_src = 0, data_clock_src = 0;
  logic [6:0] signal_strength_level = 0, carrier_threshold = 0;
  logic [7:0] subsys_done_raw = 0, adc_m = 8'h40, cpl_m = 0, stg_m = 0; // model registers
  logic [2:0] bitsync_parts_done = 0;
  logic [31:0] d, v;
  logic [1:0] p;
  logic cal_m, fail_m;                       // model status flags
  int err_count = 0, num_checks = 0;
  wire psel, penable, pwrite, pready, pslverr, lock_pin, data_pin, data_clock_pin, irq;
  wire freq_comp_out, dither_clock_enable, integrator_chop_off, feedback_shaping_off;
  wire common_mode_rotation_off, first_coupler_gain, gain_override_enable;
  wire [1:0] adc_input_position, second_coupler_gain, stage1_gain_value, stage2_gain_value;
  wire [1:0] stage3_gain_value;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  always #5 clk = ~clk;                      // 100 MHz
  rtsr_host u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
  rtsr_regs uut (.*);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] x); u_host.xfer(1, a, {24'h0, x}, d, e); endtask
  task automatic rd(input logic [11:0] a); u_host.xfer(0, a, 32'h0, d, e); endtask
  // next converter input position for a rotation mode
  function automatic logic [1:0] nxt(input logic [1:0] m, input logic [1:0] q);
    case (m)
      2'h0: nxt = q + 2'h1;
      2'h1: nxt = (q == 2'h0) ? 2'h2 : (q == 2'h2) ? 2'h3 : (q == 2'h3) ? 2'h1 : 2'h0;
      2'h2: nxt = 2'h0;
      default: nxt = (q == 2'h0) ? 2'h2 : 2'h0;
    endcase
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog far beyond the expected run
  initial begin
    #300000;
    err_count++;
    give_verdict;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(41));
    cyc(2); rst_n <= 1'b1; cyc(3);
    rd(12'h094); `CHK("adc_test", {24'h0, adc_m}, d)
    rd(12'h098); `CHK("coupler", 32'h0, d)
    rd(12'h09C); `CHK("stage", 32'h0, d)
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      cpl_m = {4'h0, ~i[2], v[2], i[1:0]};   // reserved bits written as zero
      stg_m = {2'h0, v[13:8]};
      wr(12'h098, cpl_m); wr(12'h09C, stg_m);
      rd(12'h098); `CHK("coupler", {24'h0, cpl_m}, d)
      rd(12'h09C); `CHK("stage", {24'h0, stg_m}, d)
      cyc(3);
      `CHK("gains", cpl_m[3] ? cpl_m[2:0] : 3'h0, {first_coupler_gain, second_coupler_gain})
      `CHK("stages", stg_m[5:0], {stage1_gain_value, stage2_gain_value, stage3_gain_value})
    end
    // each rotation mode, comparator gate, pin routing
    for (int m = 0; m < 4; m++) begin
      v = $urandom;
      adc_m = {m[0], v[6], m[1], v[4:2], m[1:0]};
      wr(12'h094, adc_m);
      rd(12'h094); `CHK("adc_test", {24'h0, adc_m}, d)
      `CHK("tech", adc_m[6:2] & 5'h17, {dither_clock_enable, 1'b0, integrator_chop_off,
           feedback_shaping_off, common_mode_rotation_off})
      for (int k = 0; k < 9; k++) begin
        converter_sample_clock <= 1'b1; cyc(6);
        if (k > 3) `CHK("position", nxt(m[1:0], p), adc_input_position)
        p = adc_input_position;
        converter_sample_clock <= 1'b0; cyc(6);
      end
      {freq_comp_raw, lock_src, data_src, data_clock_src, converter_sample_clock} <= v[12:8];
      {converter_sample_a, converter_sample_b} <= v[14:13];
      cyc(6);
      `CHK("fcomp", adc_m[7] & freq_comp_raw, freq_comp_out)
      `CHK("data_clock", adc_m[5] ? converter_sample_clock : data_clock_src, data_clock_pin)
      `CHK("pins", adc_m[5] ? {converter_sample_a, converter_sample_b} : {lock_src, data_src},
           {lock_pin, data_pin})
    end
    adc_m[5] = 1'b0;
    wr(12'h094, adc_m);
    wr(12'h095, 8'hFF); `CHK("slverr", 1'b1, e)
    rd(12'h094); `CHK("misaligned", {24'h0, adc_m}, d)
    // status and reset-done flags over three rounds
    for (int r = 0; r < 3; r++) begin
      if (r == 0) begin cal_start <= 1; cyc(4); cal_start <= 0; cal_m = 0; fail_m = 0; end
      if (r == 1) begin cal_end <= 1; cyc(4); cal_end <= 0; cal_m = 1; end
      if (r == 2) begin seq_lock_fail <= 1; cyc(4); seq_lock_fail <= 0; fail_m = 1; end
      v = $urandom;
      signal_strength_level <= v[6:0];
      carrier_threshold <= (r == 2) ? v[6:0] : v[13:7];
      subsys_done_raw <= v[21:14];
      bitsync_parts_done <= (r == 1) ? 3'h7 : v[24:22];
      {lock_now, lock_filtered, lock_src, data_clock_src, data_src, freq_comp_raw} <= v[30:25];
      cyc(6);
      for (int n = 0; n < 2; n++) begin
        rd(12'h100); `CHK("status", {24'h0, cal_m, fail_m, lock_now, lock_filtered,
          signal_strength_level > carrier_threshold, lock_src, data_clock_src, data_src}, d)
        rd(12'h104); `CHK("done", {24'h0, subsys_done_raw[7:4], &bitsync_parts_done,
          subsys_done_raw[2:0]}, d)
      end
      rd(12'h11C); `CHK("compare", freq_comp_raw, d[7])
    end
    // interrupt: raise, mask, unmask, clear
    wr(12'h140, 8'h0F); wr(12'h144, 8'h01); cyc(2); `CHK("irq", 1'b0, irq)
    cal_start <= 1; cyc(4); cal_start <= 0; cal_end <= 1; cyc(4); cal_end <= 0; cyc(6);
    `CHK("irq", 1'b1, irq)
    rd(12'h140); `CHK("irq_status", 1'b1, d[0])
    wr(12'h144, 8'h00); cyc(2); `CHK("irq", 1'b0, irq)
    wr(12'h144, 8'h01); cyc(2); `CHK("irq", 1'b1, irq)
    wr(12'h140, 8'h01); cyc(2); `CHK("irq", 1'b0, irq)
    rd(12'h140); `CHK("irq_status", 1'b0, d[0])
    rd(12'h200); `CHK("unmapped", {1'b1, 32'h0}, {e, d})
    give_verdict;
  end
endmodule // rtsr_regs_tb_top
`default_nettype wire
